/* include/csb_defs.svh */
/*
 Offsets, field positions, reset values and the timer-2 mode bits of the
 special register bank. Assumes inclusion by bare name from the design.
*/
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH

`define CSB_ADDR_PORT0 8'h80
`define CSB_ADDR_SP 8'h81
`define CSB_ADDR_DPL 8'h82
`define CSB_ADDR_DPH 8'h83
`define CSB_ADDR_PWR 8'h87
`define CSB_ADDR_TCTL 8'h88
`define CSB_ADDR_TMODE 8'h89
`define CSB_ADDR_T0L 8'h8a
`define CSB_ADDR_T1L 8'h8b
`define CSB_ADDR_T0H 8'h8c
`define CSB_ADDR_T1H 8'h8d
`define CSB_ADDR_AUX 8'h8e
`define CSB_ADDR_CLK 8'h8f
`define CSB_ADDR_PORT1 8'h90
`define CSB_ADDR_SCTL 8'h98
`define CSB_ADDR_SERIAL_BUFFER 8'h99
`define CSB_ADDR_PORT2 8'ha0
`define CSB_ADDR_IEN 8'ha8
`define CSB_ADDR_PORT3 8'hb0
`define CSB_ADDR_IPRI 8'hb8
`define CSB_ADDR_T2CTL 8'hc8
`define CSB_ADDR_CAPL 8'hca
`define CSB_ADDR_CAPH 8'hcb
`define CSB_ADDR_T2L 8'hcc
`define CSB_ADDR_T2H 8'hcd
`define CSB_ADDR_PSW 8'hd0
`define CSB_ADDR_ACC 8'he0
`define CSB_ADDR_MULB 8'hf0

`define CSB_RST_SP 8'h07
`define CSB_RST_PORT 8'hff
`define CSB_RST_BYTE 8'h00

`define CSB_PSW_CY 7
`define CSB_PSW_AC 6
`define CSB_PSW_F0 5
`define CSB_PSW_RS_HI 4
`define CSB_PSW_RS_LO 3
`define CSB_PSW_OV 2
`define CSB_PSW_RSVD 1
`define CSB_PSW_PAR 0

`define CSB_T2_FLAG 6
`define CSB_T2_EXEN 3
`define CSB_T2_CAPMODE 0

`endif

/* include/csb_pkg.sv */
/*
 Types of the special register bank: the whole registered state as one
 packed struct. Assumes csb_defs.svh for the numeric constants.
*/
`default_nettype none
package csb_pkg;
	typedef logic [7:0] csb_byte_t;
	typedef struct packed {
		csb_byte_t accumulator;
		csb_byte_t multiply_helper;
		csb_byte_t program_status_word;
		csb_byte_t stack_pointer;
		csb_byte_t data_pointer_low;
		csb_byte_t data_pointer_high;
		csb_byte_t [3:0] port_latch;
		csb_byte_t [7:0] ctl;
		csb_byte_t tx_hold;
		csb_byte_t rx_buf;
		logic tx_start;
		csb_byte_t [2:0] cnt_low;
		csb_byte_t [2:0] cnt_high;
		csb_byte_t timer2_control;
		csb_byte_t timer2_capture_low;
		csb_byte_t timer2_capture_high;
		logic [2:0] trig_sync;
		logic trig_level;
		csb_byte_t rdata;
	} csb_state_t;
endpackage : csb_pkg
`default_nettype wire

/* rtl/csb_core_sfr_bank.sv */
/*
 Special register bank of a small 8-bit core: decode, storage and the
 hardware side effects of its registers. Assumes one clock, a core that
 reads over the plain port with data one cycle later, and a core datapath
 that drives the hardware update strobes below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csb_defs.svh"

module csb_core_sfr_bank #(
	parameter bit HAS_TIMER2 = 1'b1,
	parameter int NUM_TIMERS = 3
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Datapath updates
	input wire logic i_acc_wr,
	input wire logic [7:0] i_acc_wdata,
	input wire logic i_muldiv_wr,
	input wire logic [7:0] i_muldiv_wdata,
	input wire logic i_flags_wr,
	input wire logic i_carry_flag,
	input wire logic i_aux_carry_flag,
	input wire logic i_overflow_flag,
	input wire logic i_sp_push,
	input wire logic i_sp_pop,
	input wire logic i_data_pointer_wr,
	input wire logic [15:0] i_data_pointer_wdata,
	// Serial and timers
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic [2:0] i_timer_tick,
	input wire logic i_timer2_overflow,
	input wire logic i_capture_trigger_input,
	// Register values for the core
	output logic [7:0] o_accumulator,
	output logic [7:0] o_multiply_helper,
	output logic [7:0] o_program_status_word,
	output logic [7:0] o_bank_base,
	output logic [7:0] o_stack_pointer,
	output logic [15:0] o_data_pointer,
	output logic [31:0] o_port_latch,
	output logic [7:0] o_tx_data,
	output logic o_tx_start,
	output logic [7:0] o_timer2_control
);

	// The map has room for exactly three count pairs, so refuse any other count at elaboration
	if (NUM_TIMERS != 3) begin : g_bad_num_timers
		$error("csb_core_sfr_bank: three timer count pairs are mapped");
	end

	// Control registers without side effects, kept in one array
	localparam int C_PWR = 0;
	localparam int C_TCTL = 1;
	localparam int C_TMODE = 2;
	localparam int C_AUX = 3;
	localparam int C_CLK = 4;
	localparam int C_SCTL = 5;
	localparam int C_IEN = 6;
	localparam int C_IPRI = 7;

	localparam csb_pkg::csb_state_t RESET_STATE = '{
		accumulator: `CSB_RST_BYTE,
		multiply_helper: `CSB_RST_BYTE,
		program_status_word: `CSB_RST_BYTE,
		stack_pointer: `CSB_RST_SP,
		data_pointer_low: `CSB_RST_BYTE,
		data_pointer_high: `CSB_RST_BYTE,
		port_latch: {4{`CSB_RST_PORT}},
		ctl: {8{`CSB_RST_BYTE}},
		tx_hold: `CSB_RST_BYTE,
		rx_buf: `CSB_RST_BYTE,
		tx_start: 1'b0,
		cnt_low: {3{`CSB_RST_BYTE}},
		cnt_high: {3{`CSB_RST_BYTE}},
		timer2_control: `CSB_RST_BYTE,
		timer2_capture_low: `CSB_RST_BYTE,
		timer2_capture_high: `CSB_RST_BYTE,
		trig_sync: 3'b111,
		trig_level: 1'b1,
		rdata: `CSB_RST_BYTE
	};

	csb_pkg::csb_state_t r;
	csb_pkg::csb_state_t next_r;

	always_comb begin
		logic wr_t2;
		logic trig_fall;
		logic [15:0] cnt;
		logic [7:0] rd;
		wr_t2 = 1'b0;
		trig_fall = 1'b0;
		cnt = 16'h0000;
		rd = 8'h00;
		next_r = r;
		next_r.tx_start = 1'b0;
		wr_t2 = i_wr && HAS_TIMER2;

		// Bus writes land at this edge
		if (i_wr) begin
			unique case (i_addr)
				`CSB_ADDR_ACC: next_r.accumulator = i_wdata;
				`CSB_ADDR_MULB: next_r.multiply_helper = i_wdata;
				`CSB_ADDR_PSW: begin
					// Parity and the reserved bit are not software writable
					next_r.program_status_word[7:2] = i_wdata[7:2];
				end
				`CSB_ADDR_SP: next_r.stack_pointer = i_wdata;
				`CSB_ADDR_DPL: next_r.data_pointer_low = i_wdata;
				`CSB_ADDR_DPH: next_r.data_pointer_high = i_wdata;
				`CSB_ADDR_PORT0: next_r.port_latch[0] = i_wdata;
				`CSB_ADDR_PORT1: next_r.port_latch[1] = i_wdata;
				`CSB_ADDR_PORT2: next_r.port_latch[2] = i_wdata;
				`CSB_ADDR_PORT3: next_r.port_latch[3] = i_wdata;
				`CSB_ADDR_PWR: next_r.ctl[C_PWR] = i_wdata;
				`CSB_ADDR_TCTL: next_r.ctl[C_TCTL] = i_wdata;
				`CSB_ADDR_TMODE: next_r.ctl[C_TMODE] = i_wdata;
				`CSB_ADDR_AUX: next_r.ctl[C_AUX] = i_wdata;
				`CSB_ADDR_CLK: next_r.ctl[C_CLK] = i_wdata;
				`CSB_ADDR_SCTL: next_r.ctl[C_SCTL] = i_wdata;
				`CSB_ADDR_IEN: next_r.ctl[C_IEN] = i_wdata;
				`CSB_ADDR_IPRI: next_r.ctl[C_IPRI] = i_wdata;
				`CSB_ADDR_SERIAL_BUFFER: begin
					next_r.tx_hold = i_wdata;
					next_r.tx_start = 1'b1;
				end
				`CSB_ADDR_T0L: next_r.cnt_low[0] = i_wdata;
				`CSB_ADDR_T1L: next_r.cnt_low[1] = i_wdata;
				`CSB_ADDR_T0H: next_r.cnt_high[0] = i_wdata;
				`CSB_ADDR_T1H: next_r.cnt_high[1] = i_wdata;
				default: begin
					// Reserved locations take no write
				end
			endcase
		end
		if (wr_t2) begin
			unique case (i_addr)
				`CSB_ADDR_T2CTL: next_r.timer2_control = i_wdata;
				`CSB_ADDR_CAPL: next_r.timer2_capture_low = i_wdata;
				`CSB_ADDR_CAPH: next_r.timer2_capture_high = i_wdata;
				`CSB_ADDR_T2L: next_r.cnt_low[2] = i_wdata;
				`CSB_ADDR_T2H: next_r.cnt_high[2] = i_wdata;
				default: begin
				end
			endcase
		end

		// Datapath updates follow the bus, so the executing instruction wins
		if (i_acc_wr) begin
			next_r.accumulator = i_acc_wdata;
		end
		if (i_muldiv_wr) begin
			next_r.multiply_helper = i_muldiv_wdata;
		end
		if (i_flags_wr) begin
			next_r.program_status_word[`CSB_PSW_CY] = i_carry_flag;
			next_r.program_status_word[`CSB_PSW_AC] = i_aux_carry_flag;
			next_r.program_status_word[`CSB_PSW_OV] = i_overflow_flag;
		end
		// Push wins over pop; the core never asks for both
		if (i_sp_push) begin
			next_r.stack_pointer = r.stack_pointer + 8'h01;
		end else if (i_sp_pop) begin
			next_r.stack_pointer = r.stack_pointer - 8'h01;
		end
		if (i_data_pointer_wr) begin
			next_r.data_pointer_high = i_data_pointer_wdata[15:8];
			next_r.data_pointer_low = i_data_pointer_wdata[7:0];
		end
		if (i_rx_valid) begin
			next_r.rx_buf = i_rx_data;
		end

		// Count pairs advance as one 16-bit value on each tick
		for (int t = 0; t < 3; t++) begin
			if (i_timer_tick[t] && (t < 2 || HAS_TIMER2)) begin
				cnt = {r.cnt_high[t], r.cnt_low[t]} + 16'h0001;
				next_r.cnt_high[t] = cnt[15:8];
				next_r.cnt_low[t] = cnt[7:0];
			end
		end

		// Trigger pin: three flops, a change counts once stages two and three agree
		next_r.trig_sync = {r.trig_sync[1:0], i_capture_trigger_input};
		if (r.trig_sync[2] == r.trig_sync[1] && r.trig_sync[2] != r.trig_level) begin
			next_r.trig_level = r.trig_sync[2];
			trig_fall = r.trig_level;
		end
		if (HAS_TIMER2) begin
			if (trig_fall && r.timer2_control[`CSB_T2_EXEN]) begin
				// Flag set wins over a bus clear in the same cycle
				next_r.timer2_control[`CSB_T2_FLAG] = 1'b1;
				if (r.timer2_control[`CSB_T2_CAPMODE]) begin
					next_r.timer2_capture_high = r.cnt_high[2];
					next_r.timer2_capture_low = r.cnt_low[2];
				end else begin
					next_r.cnt_high[2] = r.timer2_capture_high;
					next_r.cnt_low[2] = r.timer2_capture_low;
				end
			end
			if (i_timer2_overflow && !r.timer2_control[`CSB_T2_CAPMODE]) begin
				next_r.cnt_high[2] = r.timer2_capture_high;
				next_r.cnt_low[2] = r.timer2_capture_low;
			end
		end

		// Parity follows the accumulator value of the same edge
		next_r.program_status_word[`CSB_PSW_PAR] = ^next_r.accumulator;
		next_r.program_status_word[`CSB_PSW_RSVD] = 1'b0;

		// Read data stands in the cycle after the strobe only
		if (i_rd) begin
			unique case (i_addr)
				`CSB_ADDR_ACC: rd = r.accumulator;
				`CSB_ADDR_MULB: rd = r.multiply_helper;
				`CSB_ADDR_PSW: rd = r.program_status_word;
				`CSB_ADDR_SP: rd = r.stack_pointer;
				`CSB_ADDR_DPL: rd = r.data_pointer_low;
				`CSB_ADDR_DPH: rd = r.data_pointer_high;
				`CSB_ADDR_PORT0: rd = r.port_latch[0];
				`CSB_ADDR_PORT1: rd = r.port_latch[1];
				`CSB_ADDR_PORT2: rd = r.port_latch[2];
				`CSB_ADDR_PORT3: rd = r.port_latch[3];
				`CSB_ADDR_PWR: rd = r.ctl[C_PWR];
				`CSB_ADDR_TCTL: rd = r.ctl[C_TCTL];
				`CSB_ADDR_TMODE: rd = r.ctl[C_TMODE];
				`CSB_ADDR_AUX: rd = r.ctl[C_AUX];
				`CSB_ADDR_CLK: rd = r.ctl[C_CLK];
				`CSB_ADDR_SCTL: rd = r.ctl[C_SCTL];
				`CSB_ADDR_IEN: rd = r.ctl[C_IEN];
				`CSB_ADDR_IPRI: rd = r.ctl[C_IPRI];
				`CSB_ADDR_SERIAL_BUFFER: rd = r.rx_buf;
				`CSB_ADDR_T0L: rd = r.cnt_low[0];
				`CSB_ADDR_T1L: rd = r.cnt_low[1];
				`CSB_ADDR_T0H: rd = r.cnt_high[0];
				`CSB_ADDR_T1H: rd = r.cnt_high[1];
				`CSB_ADDR_T2CTL: rd = HAS_TIMER2 ? r.timer2_control : 8'h00;
				`CSB_ADDR_CAPL: rd = HAS_TIMER2 ? r.timer2_capture_low : 8'h00;
				`CSB_ADDR_CAPH: rd = HAS_TIMER2 ? r.timer2_capture_high : 8'h00;
				`CSB_ADDR_T2L: rd = HAS_TIMER2 ? r.cnt_low[2] : 8'h00;
				`CSB_ADDR_T2H: rd = HAS_TIMER2 ? r.cnt_high[2] : 8'h00;
				default: rd = 8'h00;
			endcase
		end
		next_r.rdata = rd;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst)
			r <= RESET_STATE;
		else
			r <= next_r;
	end

	assign o_rdata = r.rdata;
	assign o_accumulator = r.accumulator;
	assign o_multiply_helper = r.multiply_helper;
	assign o_program_status_word = r.program_status_word;
	// Bank base is the select bits times eight
	assign o_bank_base = {3'b000, r.program_status_word[`CSB_PSW_RS_HI:`CSB_PSW_RS_LO], 3'b000};
	assign o_stack_pointer = r.stack_pointer;
	assign o_data_pointer = {r.data_pointer_high, r.data_pointer_low};
	assign o_port_latch = r.port_latch;
	assign o_tx_data = r.tx_hold;
	assign o_tx_start = r.tx_start;
	assign o_timer2_control = r.timer2_control;

endmodule : csb_core_sfr_bank
`default_nettype wire

/* tb/csb_chk.sv */
/* Checker of the register bank port relations.
 Assumes binding into csb_core_sfr_bank. */
`timescale 1ns/1ps
`default_nettype none
module csb_chk (
	// Clock, reset and requests
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_acc_wr,
	input wire logic i_sp_push,
	// Observed outputs
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_accumulator,
	input wire logic [7:0] o_program_status_word,
	input wire logic [7:0] o_bank_base,
	input wire logic [7:0] o_stack_pointer,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_start
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// Parity follows the accumulator in the very same cycle
	property p_par; o_program_status_word[0] == ^o_accumulator; endproperty
	a_par: assert property (p_par) else $error("parity wrong");
	property p_sp; i_sp_push |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01; endproperty
	a_sp: assert property (p_sp) else $error("push wrong");
	property p_rst; $fell(i_srst) |-> o_stack_pointer == 8'h07; endproperty
	a_rst: assert property (p_rst) else $error("stack reset wrong");
	property p_acc; i_wr && i_addr == 8'he0 && !i_acc_wr |=> o_accumulator == $past(i_wdata); endproperty
	a_acc: assert property (p_acc) else $error("acc write lost");
	property p_tx; i_wr && i_addr == 8'h99 |=> o_tx_start && o_tx_data == $past(i_wdata); endproperty
	a_tx: assert property (p_tx) else $error("send not started");
	property p_rd; i_rd && i_addr == 8'he0 |=> o_rdata == $past(o_accumulator); endproperty
	a_rd: assert property (p_rd) else $error("acc read wrong");
	property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside slot");
	property p_bank; o_bank_base == {3'h0, o_program_status_word[4:3], 3'h0}; endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");
	property p_rsv; o_program_status_word[1] == 1'b0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	c_push: cover property (i_sp_push);
	c_tx: cover property (o_tx_start);
	c_rd: cover property (i_rd && i_addr == 8'hd0);
endmodule : csb_chk
bind csb_core_sfr_bank csb_chk u_chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .i_acc_wr(i_acc_wr), .i_sp_push(i_sp_push), .o_rdata(o_rdata),
	.o_accumulator(o_accumulator), .o_program_status_word(o_program_status_word), .o_bank_base(o_bank_base),
	.o_stack_pointer(o_stack_pointer), .o_tx_data(o_tx_data), .o_tx_start(o_tx_start));
`default_nettype wire

/* tb/csb_core_model.sv */
/* Core datapath model strobing register updates.
 Assumes the bench slices o_stb and o_dat. */
`timescale 1ns/1ps
`default_nettype none
module csb_core_model (
	// Clock
	input wire logic i_mclk,
	// Strobes and data
	output logic [6:0] o_stb,
	output logic [15:0] o_dat
);
	initial begin
		o_stb = 7'h00;
		o_dat = 16'h0000;
	end
	// Bit k of o_stb strobes one datapath update for a single cycle, with v on o_dat
	task op(input int k, input logic [15:0] v);
		@(posedge i_mclk);
		o_stb <= 7'h01 << k;
		o_dat <= v;
		@(posedge i_mclk);
		o_stb <= 7'h00;
		o_dat <= ~v; // Stale data inverted, never held
		#1;
	endtask : op
endmodule : csb_core_model
`default_nettype wire

/* tb/testbench.sv */
/* Bench for the register bank through bus tasks.
 Assumes the model drives the datapath strobes. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic [2:0] i_timer_tick = 3'h0;
	logic i_timer2_overflow = 1'b0;
	logic i_capture_trigger_input = 1'b1;
	logic [6:0] stb;
	logic [15:0] dat;
	logic [7:0] o_rdata, o_accumulator, o_multiply_helper, o_program_status_word;
	logic [7:0] o_bank_base, o_stack_pointer, o_tx_data, o_timer2_control;
	logic [15:0] o_data_pointer;
	logic [31:0] o_port_latch;
	logic o_tx_start;
	logic [7:0] rdata_nt2;
	int miscompares = 0;
	int n_checks = 0;
	logic [7:0] am [26] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c,
		8'h8d, 8'h8e, 8'h8f, 8'h90, 8'h98, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hca, 8'hcb,
		8'hcc, 8'hcd, 8'he0, 8'hf0};
	csb_core_model core (.i_mclk(i_mclk), .o_stb(stb), .o_dat(dat));
	csb_core_sfr_bank dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_acc_wr(stb[0]), .i_acc_wdata(dat[7:0]),
		.i_muldiv_wr(stb[1]), .i_muldiv_wdata(dat[7:0]), .i_flags_wr(stb[2]), .i_carry_flag(dat[7]),
		.i_aux_carry_flag(dat[6]), .i_overflow_flag(dat[2]), .i_sp_push(stb[3]),
		.i_sp_pop(stb[4]), .i_data_pointer_wr(stb[5]), .i_data_pointer_wdata(dat), .i_rx_valid(stb[6]),
		.i_rx_data(dat[7:0]), .i_timer_tick(i_timer_tick), .i_timer2_overflow(i_timer2_overflow),
		.i_capture_trigger_input(i_capture_trigger_input), .o_accumulator(o_accumulator),
		.o_multiply_helper(o_multiply_helper), .o_program_status_word(o_program_status_word),
		.o_bank_base(o_bank_base), .o_stack_pointer(o_stack_pointer), .o_data_pointer(o_data_pointer),
		.o_port_latch(o_port_latch), .o_tx_data(o_tx_data), .o_tx_start(o_tx_start),
		.o_timer2_control(o_timer2_control));
	// Variant without the third timer sees the same traffic
	csb_core_sfr_bank #(.HAS_TIMER2(1'b0), .NUM_TIMERS(3)) dut_no_t2 (.i_mclk(i_mclk), .i_srst(i_srst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata_nt2),
		.i_acc_wr(stb[0]), .i_acc_wdata(dat[7:0]), .i_muldiv_wr(stb[1]), .i_muldiv_wdata(dat[7:0]),
		.i_flags_wr(stb[2]), .i_carry_flag(dat[7]), .i_aux_carry_flag(dat[6]), .i_overflow_flag(dat[2]),
		.i_sp_push(stb[3]), .i_sp_pop(stb[4]), .i_data_pointer_wr(stb[5]), .i_data_pointer_wdata(dat),
		.i_rx_valid(stb[6]), .i_rx_data(dat[7:0]), .i_timer_tick(i_timer_tick),
		.i_timer2_overflow(i_timer2_overflow), .i_capture_trigger_input(i_capture_trigger_input),
		.o_accumulator(), .o_multiply_helper(), .o_program_status_word(), .o_bank_base(),
		.o_stack_pointer(), .o_data_pointer(), .o_port_latch(), .o_tx_data(), .o_tx_start(),
		.o_timer2_control());
	initial forever #4 i_mclk = ~i_mclk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			miscompares++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		i_wdata <= ~d;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask : rd
	task pulse(input logic [3:0] v);
		@(posedge i_mclk);
		{i_timer2_overflow, i_timer_tick} <= v;
		@(posedge i_mclk);
		{i_timer2_overflow, i_timer_tick} <= 4'h0;
		#1;
	endtask : pulse
	task conclude;
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge i_mclk);
		miscompares++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge i_mclk);
		i_srst <= 1'b0;
		rd(8'h81, 8'h07);
		chk(o_port_latch, 32'hffffffff);
		rd(8'h80, 8'hff);
		// Only mapped addresses are ever written; reserved ones are only read
		foreach (am[i]) begin
			wr(am[i], am[i] ^ 8'h5a);
			rd(am[i], am[i] ^ 8'h5a);
			chk(rdata_nt2, (am[i] >= 8'hc8 && am[i] <= 8'hcd) ? 8'h00 : am[i] ^ 8'h5a);
		end
		chk(o_port_latch, 32'heafacada);
		rd(8'hc0, 8'h00);
		// Low bits are written high; bit 1 must read back clear, bit 0 reads the accumulator parity, which is set here
		for (int b = 0; b < 4; b++) begin
			wr(8'hd0, 8'(b << 3) | 8'h03);
			chk(o_bank_base, 8'(b << 3));
			rd(8'hd0, 8'(b << 3) | 8'h01);
		end
		core.op(0, 16'h0003);
		rd(8'hd0, 8'h18);
		core.op(0, 16'h0007);
		wr(8'hd0, 8'h20);
		core.op(2, 16'h0084);
		rd(8'hd0, 8'ha5);
		core.op(1, 16'h0077);
		rd(8'hf0, 8'h77);
		chk(o_multiply_helper, 8'h77);
		core.op(5, 16'h1234);
		chk(o_data_pointer, 16'h1234);
		rd(8'h82, 8'h34);
		rd(8'h83, 8'h12);
		wr(8'h81, 8'hff);
		core.op(3, 16'h0000);
		chk(o_stack_pointer, 8'h00);
		core.op(4, 16'h0000);
		chk(o_stack_pointer, 8'hff);
		core.op(6, 16'h003c);
		wr(8'h99, 8'ha5);
		chk({o_tx_start, o_tx_data}, 9'h1a5);
		rd(8'h99, 8'h3c);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'h00);
		pulse(4'h1);
		rd(8'h8c, 8'h01);
		rd(8'h8a, 8'h00);
		wr(8'hcc, 8'h11);
		wr(8'hcd, 8'h22);
		wr(8'hc8, 8'h09);
		@(posedge i_mclk);
		i_capture_trigger_input <= 1'b0;
		repeat (6) @(posedge i_mclk);
		rd(8'hca, 8'h11);
		rd(8'hcb, 8'h22);
		rd(8'hc8, 8'h49);
		chk(o_timer2_control, 8'h49);
		wr(8'hc8, 8'h08);
		wr(8'hca, 8'h55);
		wr(8'hcb, 8'h66);
		pulse(4'h8);
		rd(8'hcc, 8'h55);
		rd(8'hcd, 8'h66);
		conclude();
	end
endmodule : testbench
`default_nettype wire
